// ===== common/pdsr_pkg.sv
// Purpose: Constants for the processor debug and status register bank
// Assumes: Status-register index space of 8 bits, 32-bit data words
// Notes:   Offsets are register indices of the status-register space
//
// Contract
// RL1 - Four read-only oscillator counts, 16-bit value in low bits, upper bits zero
// RL2 - Oscillator counts survive a system reset; only power-on clears them
// RL3 - Read-only memory size in bytes in bits 31:2, bits 1:0 zero
// RL4 - Debug entry captures the interrupted thread's saved status word
// RL5 - Status copy flags: bits 0-4, 6, 7 as listed; bit 5 reserved
// RL6 - Bit 8 reads live issue mode; bit 9 kernel issue mode; bit 10 space id
// RL7 - Debug entry captures the saved program counter into a 32-bit register
// RL8 - Debug entry captures the saved stack pointer into a 32-bit register
// RL9 - Debugger sets 8-bit thread operand; device selects fetched thread from it
// RL10 - Debugger sets 5-bit register operand; device selects fetched register from it
// RL11 - Debug cause is a 3-bit code resetting to zero, codes one to five
// RL12 - Two-bit source field, forced zero for host and debug-call causes
// RL13 - Simultaneous breakpoint hits report the lowest-numbered one
// RL14 - Eight-bit causing-thread field, zero for host-requested interrupts
// RL15 - Payload gets data address on data watch, resource id on resource watch
// RL16 - On leaving debug, threads set in the stop mask do not execute
// RL17 - Stop mask is 8 bits, one per thread, blocking outside debug mode
// RL18 - Eight scratch words shared with the tile configuration scratch space
// RL19 - Reserved bits read as zero and ignore writes
// RL20 - Debug-writable fields accept writes only from a thread in debug mode
// RL21 - Software reads oscillator counts only ten cycles after stopping them
`default_nettype none
package pdsr_pkg;
  localparam int unsigned DW = 32;
  localparam int unsigned AW = 8;
  localparam int unsigned THR_N = 8;
  localparam int unsigned OSC_N = 4;
  localparam int unsigned OSC_W = 16;
  localparam int unsigned STAT_W = 11;
  localparam int unsigned SCR_N = 8;
  localparam int unsigned SCR_IW = 3;
  localparam int unsigned HIT_N = 4;
  localparam int unsigned SYNC_N = 3;
  typedef logic [AW-1:0] pdsr_addr_t;
  typedef logic [DW-1:0] pdsr_word_t;
  // Register indices
  localparam pdsr_addr_t A_OSC0 = 8'h07;
  localparam pdsr_addr_t A_OSC1 = 8'h08;
  localparam pdsr_addr_t A_OSC2 = 8'h09;
  localparam pdsr_addr_t A_OSC3 = 8'h0A;
  localparam pdsr_addr_t A_MEMSZ = 8'h0C;
  localparam pdsr_addr_t A_STAT = 8'h10;
  localparam pdsr_addr_t A_SAVPC = 8'h11;
  localparam pdsr_addr_t A_SAVSP = 8'h12;
  localparam pdsr_addr_t A_TSEL = 8'h13;
  localparam pdsr_addr_t A_RSEL = 8'h14;
  localparam pdsr_addr_t A_CAUSE = 8'h15;
  localparam pdsr_addr_t A_PAYLD = 8'h16;
  localparam pdsr_addr_t A_STOP = 8'h18;
  localparam pdsr_addr_t A_SCR0 = 8'h20;
  // Field layout
  localparam logic [STAT_W-1:0] STAT_WMASK = 11'h6DF;
  localparam int unsigned STAT_ISSUE_BIT = 8;
  localparam int unsigned MEMSZ_LSB = 2;
  localparam int unsigned THR_LSB = 8;
  localparam int unsigned SRC_LSB = 16;
  localparam int unsigned RSEL_W = 5;
  localparam int unsigned CAUSE_W = 3;
  localparam int unsigned SRC_W = 2;
  // Cause codes
  localparam logic [CAUSE_W-1:0] C_NONE = 3'h0;
  localparam logic [CAUSE_W-1:0] C_HOST = 3'h1;
  localparam logic [CAUSE_W-1:0] C_DBGCALL = 3'h2;
  localparam logic [CAUSE_W-1:0] C_IBRK = 3'h3;
  localparam logic [CAUSE_W-1:0] C_DWATCH = 3'h4;
  localparam logic [CAUSE_W-1:0] C_RWATCH = 3'h5;
  localparam pdsr_word_t MEM_BYTES_DEF = 32'h0001_0000;
endpackage : pdsr_pkg
`default_nettype wire

// ===== rtl/pdsr_regs.sv
// Purpose: Processor debug and status register bank of one tile
// Assumes: Status-register port driven by the core on clk_i; osc_i raw async
// Notes:   Read data appears one cycle after the request; por_i clears counts
`default_nettype none
module pdsr_regs
  import pdsr_pkg::*;
#(
  parameter pdsr_pkg::pdsr_word_t MEM_BYTES = pdsr_pkg::MEM_BYTES_DEF
) (
  input  wire  logic                         clk_i,
  input  wire  logic                         rst_i,
  input  wire  logic                         por_i,
  input  wire  logic                         ps_wr_i,
  input  wire  logic                         ps_rd_i,
  input  wire  pdsr_pkg::pdsr_addr_t         ps_addr_i,
  input  wire  pdsr_pkg::pdsr_word_t         ps_wdata_i,
  input  wire  logic                         ps_dbg_i,
  output var   pdsr_pkg::pdsr_word_t         ps_rdata_o,
  output var   logic                         ps_rvalid_o,
  input  wire  logic                         cfg_wr_i,
  input  wire  logic                         cfg_rd_i,
  input  wire  logic [pdsr_pkg::SCR_IW-1:0]  cfg_idx_i,
  input  wire  pdsr_pkg::pdsr_word_t         cfg_wdata_i,
  output var   pdsr_pkg::pdsr_word_t         cfg_rdata_o,
  input  wire  logic                         dbg_mode_i,
  input  wire  logic                         dbg_entry_i,
  input  wire  logic [pdsr_pkg::STAT_W-1:0]  entry_status_i,
  input  wire  pdsr_pkg::pdsr_word_t         entry_pc_i,
  input  wire  pdsr_pkg::pdsr_word_t         entry_sp_i,
  input  wire  logic [pdsr_pkg::CAUSE_W-1:0] entry_cause_i,
  input  wire  logic [pdsr_pkg::THR_N-1:0]   entry_thread_i,
  input  wire  logic [pdsr_pkg::HIT_N-1:0]   entry_hits_i,
  input  wire  pdsr_pkg::pdsr_word_t         entry_addr_i,
  input  wire  pdsr_pkg::pdsr_word_t         entry_res_id_i,
  input  wire  logic                         issue_mode_i,
  input  wire  logic [pdsr_pkg::OSC_N-1:0]   osc_i,
  output var   logic [pdsr_pkg::THR_N-1:0]   fetch_thread_o,
  output var   logic [pdsr_pkg::RSEL_W-1:0]  fetch_reg_o,
  output var   logic [pdsr_pkg::THR_N-1:0]   thread_stop_o
);
  import pdsr_pkg::*;

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [STAT_W-1:0]          stat;
    pdsr_word_t                 pc;
    pdsr_word_t                 sp;
    logic [THR_N-1:0]           tsel;
    logic [RSEL_W-1:0]          rsel;
    logic [CAUSE_W-1:0]         cause;
    logic [SRC_W-1:0]           src;
    logic [THR_N-1:0]           thr;
    pdsr_word_t                 payld;
    logic [THR_N-1:0]           mask;
    logic [SCR_N-1:0][DW-1:0]   scr;
    logic [THR_N-1:0]           stop;
    pdsr_word_t                 ps_rdata;
    logic                       ps_rvalid;
    pdsr_word_t                 cfg_rdata;
  } pdsr_state_t;

  // Oscillator side kept apart so a system reset leaves it alone
  typedef struct packed {
    logic [OSC_N-1:0][SYNC_N-1:0] sync;
    logic [OSC_N-1:0]             level;
    logic [OSC_N-1:0][OSC_W-1:0]  cnt;
  } pdsr_osc_t;

  pdsr_state_t s;
  pdsr_state_t next_s;
  pdsr_osc_t   o;
  pdsr_osc_t   next_o;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic is_scratch(input pdsr_addr_t a);
    is_scratch = (a[AW-1:SCR_IW] == A_SCR0[AW-1:SCR_IW]);
  endfunction

  function automatic pdsr_word_t zext16(input logic [OSC_W-1:0] v);
    zext16 = {{(DW-OSC_W){1'b0}}, v};
  endfunction

  // RL13 lowest hit wins
  function automatic logic [SRC_W-1:0] lowest_hit(input logic [HIT_N-1:0] h);
    logic [SRC_W-1:0] r;
    r = '0;
    for (int i = HIT_N - 1; i >= 0; i--) begin
      if (h[i]) begin
        r = SRC_W'(i);
      end
    end
    lowest_hit = r;
  endfunction

  // ****************************************
  // Read multiplexer
  // ****************************************
  function automatic pdsr_word_t rd_word(input pdsr_state_t st,
                                         input pdsr_osc_t   os,
                                         input pdsr_addr_t  a,
                                         input logic        im);
    pdsr_word_t r;
    r = '0;
    // RL19 reserved bits zero
    if (is_scratch(a)) begin
      r = st.scr[a[SCR_IW-1:0]];
    end else begin
      case (a)
        // RL1 counts in low bits
        A_OSC0:  r = zext16(os.cnt[0]);
        A_OSC1:  r = zext16(os.cnt[1]);
        A_OSC2:  r = zext16(os.cnt[2]);
        A_OSC3:  r = zext16(os.cnt[3]);
        // RL3 size with low bits clear
        A_MEMSZ: r = {MEM_BYTES[DW-1:MEMSZ_LSB], {MEMSZ_LSB{1'b0}}};
        A_STAT: begin
          r[STAT_W-1:0] = st.stat;
          // RL6 live issue mode
          r[STAT_ISSUE_BIT] = im;
        end
        A_SAVPC: r = st.pc;
        A_SAVSP: r = st.sp;
        A_TSEL:  r[THR_N-1:0] = st.tsel;
        A_RSEL:  r[RSEL_W-1:0] = st.rsel;
        A_CAUSE: begin
          r[CAUSE_W-1:0] = st.cause;
          r[THR_LSB +: THR_N] = st.thr;
          r[SRC_LSB +: SRC_W] = st.src;
        end
        A_PAYLD: r = st.payld;
        A_STOP:  r[THR_N-1:0] = st.mask;
        default: r = '0;
      endcase
    end
    rd_word = r;
  endfunction

  // ****************************************
  // Oscillator counters
  // ****************************************
  always_comb begin
    next_o = o;
    for (int i = 0; i < OSC_N; i++) begin
      next_o.sync[i] = {o.sync[i][SYNC_N-2:0], osc_i[i]};
      // RL21 counts are only stable once the oscillator is stopped
      if ((o.sync[i][1] == o.sync[i][2]) && (o.sync[i][2] != o.level[i])) begin
        next_o.level[i] = o.sync[i][2];
        if (o.sync[i][2]) begin
          next_o.cnt[i] = o.cnt[i] + OSC_W'(1);
        end
      end
    end
  end

  // RL2 cleared by power-on only
  always_ff @(posedge clk_i or posedge por_i) begin
    if (por_i) begin
      o <= '0;
    end else begin
      o <= next_o;
    end
  end

  // ****************************************
  // Register updates
  // ****************************************
  logic ps_wen;
  logic [SCR_IW-1:0] ps_idx;

  // RL20 debug-only writes
  assign ps_wen = ps_wr_i && ps_dbg_i;
  assign ps_idx = ps_addr_i[SCR_IW-1:0];

  always_comb begin
    next_s = s;
    next_s.ps_rvalid = ps_rd_i;
    if (ps_rd_i) begin
      next_s.ps_rdata = rd_word(s, o, ps_addr_i, issue_mode_i);
    end
    if (cfg_rd_i) begin
      next_s.cfg_rdata = s.scr[cfg_idx_i];
    end

    // RL18 config-space writes share storage
    if (cfg_wr_i) begin
      next_s.scr[cfg_idx_i] = cfg_wdata_i;
    end

    if (ps_wen) begin
      if (is_scratch(ps_addr_i)) begin
        // RL18 status-space port takes priority on a clash
        next_s.scr[ps_idx] = ps_wdata_i;
      end else begin
        case (ps_addr_i)
          A_STAT: begin
            // RL5 keep reserved and read-only bits
            // RL19 writes to reserved bits dropped
            next_s.stat = (s.stat & ~STAT_WMASK) | (ps_wdata_i[STAT_W-1:0] & STAT_WMASK);
          end
          A_SAVPC: next_s.pc = ps_wdata_i;
          A_SAVSP: next_s.sp = ps_wdata_i;
          // RL9 thread operand
          A_TSEL:  next_s.tsel = ps_wdata_i[THR_N-1:0];
          // RL10 register operand
          A_RSEL:  next_s.rsel = ps_wdata_i[RSEL_W-1:0];
          A_CAUSE: begin
            next_s.cause = ps_wdata_i[CAUSE_W-1:0];
            next_s.thr = ps_wdata_i[THR_LSB +: THR_N];
            next_s.src = ps_wdata_i[SRC_LSB +: SRC_W];
          end
          A_PAYLD: next_s.payld = ps_wdata_i;
          // RL17 one bit per thread
          A_STOP:  next_s.mask = ps_wdata_i[THR_N-1:0];
          default: next_s.mask = s.mask;
        endcase
      end
    end

    // Capture on debug entry overrides a same-cycle write
    if (dbg_entry_i) begin
      // RL4 status capture
      // RL5 bit 5 stays clear
      next_s.stat = entry_status_i & STAT_WMASK;
      next_s.stat[STAT_ISSUE_BIT] = entry_status_i[STAT_ISSUE_BIT];
      // RL7 program counter capture
      next_s.pc = entry_pc_i;
      // RL8 stack pointer capture
      next_s.sp = entry_sp_i;
      // RL11 cause code
      next_s.cause = entry_cause_i;
      // RL12 source zero for host and call
      case (entry_cause_i)
        C_IBRK, C_DWATCH, C_RWATCH: next_s.src = lowest_hit(entry_hits_i);
        default:                    next_s.src = '0;
      endcase
      // RL14 thread zero for host
      next_s.thr = (entry_cause_i == C_HOST) ? '0 : entry_thread_i;
      // RL15 address or resource id
      case (entry_cause_i)
        C_DWATCH: next_s.payld = entry_addr_i;
        C_RWATCH: next_s.payld = entry_res_id_i;
        default:  next_s.payld = s.payld;
      endcase
    end

    // RL16 stopped threads held once debug ends
    // RL17 mask acts outside debug only
    next_s.stop = dbg_mode_i ? '0 : next_s.mask;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      // RL11 cause resets to none
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign ps_rdata_o     = s.ps_rdata;
  assign ps_rvalid_o    = s.ps_rvalid;
  assign cfg_rdata_o    = s.cfg_rdata;
  // RL9 selected thread
  assign fetch_thread_o = s.tsel;
  // RL10 selected register
  assign fetch_reg_o    = s.rsel;
  assign thread_stop_o  = s.stop;

endmodule : pdsr_regs
`default_nettype wire

// ===== tb/pdsr_regs_checker.sv
// Purpose: Port assertions for the debug and status register bank
// Assumes: One clock domain, rst_i asynchronous active high
// Notes:   Read data is judged one cycle after the read strobe
`default_nettype none
module pdsr_regs_checker
  import pdsr_pkg::*;
(
  input wire logic                         clk_i,
  input wire logic                         rst_i,
  input wire logic                         ps_rd_i,
  input wire logic                         ps_wr_i,
  input wire pdsr_pkg::pdsr_addr_t         ps_addr_i,
  input wire pdsr_pkg::pdsr_word_t         ps_rdata_o,
  input wire logic                         ps_rvalid_o,
  input wire logic                         issue_mode_i,
  input wire logic                         dbg_mode_i,
  input wire logic                         dbg_entry_i,
  input wire logic [pdsr_pkg::CAUSE_W-1:0] entry_cause_i,
  input wire logic [pdsr_pkg::RSEL_W-1:0]  fetch_reg_o,
  input wire logic [pdsr_pkg::THR_N-1:0]   thread_stop_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_osc_upper: assert property (
    ps_rd_i && ps_addr_i inside {[A_OSC0:A_OSC3]} |=> ps_rvalid_o && ps_rdata_o[31:16] == 16'h0)
    else $error("oscillator upper bits set");
  a_mem_low: assert property (ps_rd_i && ps_addr_i == A_MEMSZ |=> ps_rdata_o[1:0] == 2'h0)
    else $error("memory size low bits set");
  a_stat_resv: assert property (
    ps_rd_i && ps_addr_i == A_STAT |=> ps_rdata_o[31:11] == 21'h0 && !ps_rdata_o[5])
    else $error("status copy reserved bits set");
  a_issue_live: assert property (
    ps_rd_i && ps_addr_i == A_STAT |=> ps_rdata_o[STAT_ISSUE_BIT] == $past(issue_mode_i))
    else $error("issue mode bit not live");
  a_cause_code: assert property (
    ps_rd_i && ps_addr_i == A_CAUSE |=> ps_rdata_o[31:18] == 14'h0 && ps_rdata_o[7:3] == 5'h0)
    else $error("cause reserved bits set");
  a_host_zero: assert property (
    dbg_entry_i && entry_cause_i == C_HOST ##1 !ps_wr_i && !dbg_entry_i
    ##1 ps_rd_i && ps_addr_i == A_CAUSE && !dbg_entry_i
    |=> ps_rdata_o[17:8] == 10'h0)
    else $error("host cause with source or thread");
  a_rsel_copy: assert property (
    ps_rd_i && ps_addr_i == A_RSEL && !ps_wr_i |=> ps_rdata_o == {27'h0, fetch_reg_o})
    else $error("register operand mismatch");
  a_stop_dbg: assert property (dbg_mode_i |=> thread_stop_o == 8'h00)
    else $error("thread stopped in debug mode");
  a_unmapped: assert property (ps_rd_i && ps_addr_i == 8'h0B |=> ps_rdata_o == 32'h0)
    else $error("unmapped read not zero");
  cover property (dbg_entry_i && entry_cause_i == C_RWATCH);
  cover property ($fell(dbg_mode_i));
  cover property (ps_rd_i && ps_addr_i == A_MEMSZ);
endmodule // pdsr_regs_checker
bind pdsr_regs pdsr_regs_checker u_chk (.clk_i, .rst_i, .ps_rd_i, .ps_wr_i, .ps_addr_i, .ps_rdata_o, .ps_rvalid_o,
  .issue_mode_i, .dbg_mode_i, .dbg_entry_i, .entry_cause_i, .fetch_reg_o, .thread_stop_o);
`default_nettype wire

// ===== tb/pdsr_dbg_model.sv
// Purpose: External debugger on the tile-config scratch port
// Assumes: Requests launched on the falling edge of clk_i
// Notes:   Idle write data is inverted so a stale word never looks valid
`default_nettype none
module pdsr_dbg_model
  import pdsr_pkg::*;
(
  input  wire logic                        clk_i,
  input  wire pdsr_pkg::pdsr_word_t        cfg_rdata_i,
  output var  logic                        cfg_wr_o,
  output var  logic                        cfg_rd_o,
  output var  logic [pdsr_pkg::SCR_IW-1:0] cfg_idx_o,
  output var  pdsr_pkg::pdsr_word_t        cfg_wdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cfg_wr_o = 1'b0;
    cfg_rd_o = 1'b0;
    cfg_idx_o = 3'h0;
    cfg_wdata_o = 32'h0;
  end
  task automatic put(input logic [SCR_IW-1:0] i, input pdsr_word_t d);
    @(negedge clk_i);
    cfg_wr_o = 1'b1;
    cfg_idx_o = i;
    cfg_wdata_o = d;
    @(negedge clk_i);
    cfg_wr_o = 1'b0;
    cfg_wdata_o = ~d;
  endtask
  task automatic get(input logic [SCR_IW-1:0] i, output pdsr_word_t d);
    @(negedge clk_i);
    cfg_rd_o = 1'b1;
    cfg_idx_o = i;
    @(negedge clk_i);
    cfg_rd_o = 1'b0;
    d = cfg_rdata_i;
  endtask
endmodule // pdsr_dbg_model
`default_nettype wire

// ===== tb/testbench.sv
// Purpose: Self-checking bench for the debug and status register bank
// Assumes: Inputs change on the falling edge of clk_i
// Notes:   Oscillators toggle slowly so their counts are exact
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import pdsr_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, por_i = 1'b1, ps_wr_i = 1'b0, ps_rd_i = 1'b0, ps_dbg_i = 1'b0;
  logic dbg_mode_i = 1'b0, dbg_entry_i = 1'b0, issue_mode_i = 1'b0, ps_rvalid_o, cfg_wr_i, cfg_rd_i;
  logic [SCR_IW-1:0]  cfg_idx_i;
  logic [CAUSE_W-1:0] entry_cause_i = 3'h0;
  logic [THR_N-1:0]   entry_thread_i = 8'h00, fetch_thread_o, thread_stop_o;
  logic [HIT_N-1:0]   entry_hits_i = 4'h0;
  logic [OSC_N-1:0]   osc_i = 4'h0;
  logic [RSEL_W-1:0]  fetch_reg_o;
  logic [STAT_W-1:0]  entry_status_i = 11'h7FF;
  pdsr_addr_t         ps_addr_i = 8'h00;
  pdsr_word_t         ps_wdata_i = 32'h0, ps_rdata_o, cfg_wdata_i, cfg_rdata_o, pay = 32'h0, d;
  pdsr_word_t         entry_pc_i = 32'h8000_1234, entry_sp_i = 32'h0001_FFF0;
  pdsr_word_t         entry_addr_i = 32'hA000_0040, entry_res_id_i = 32'h0000_0A0B;
  int                 n_mismatch = 0, n_checks = 0;
  pdsr_regs u_dut (.clk_i, .rst_i, .por_i, .ps_wr_i, .ps_rd_i, .ps_addr_i, .ps_wdata_i, .ps_dbg_i, .ps_rdata_o,
    .ps_rvalid_o, .cfg_wr_i, .cfg_rd_i, .cfg_idx_i, .cfg_wdata_i, .cfg_rdata_o, .dbg_mode_i, .dbg_entry_i,
    .entry_status_i, .entry_pc_i, .entry_sp_i, .entry_cause_i, .entry_thread_i, .entry_hits_i, .entry_addr_i,
    .entry_res_id_i, .issue_mode_i, .osc_i, .fetch_thread_o, .fetch_reg_o, .thread_stop_o);
  pdsr_dbg_model u_dbg (.clk_i, .cfg_rdata_i(cfg_rdata_o), .cfg_wr_o(cfg_wr_i), .cfg_rd_o(cfg_rd_i),
    .cfg_idx_o(cfg_idx_i), .cfg_wdata_o(cfg_wdata_i));
  always #5 clk_i = ~clk_i;
  task automatic chk(input pdsr_word_t got, input pdsr_word_t exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input pdsr_addr_t a, input pdsr_word_t v, input logic g);
    @(negedge clk_i);
    ps_wr_i = 1'b1;
    ps_dbg_i = g;
    ps_addr_i = a;
    ps_wdata_i = v;
    @(negedge clk_i);
    ps_wr_i = 1'b0;
  endtask
  task automatic rc(input pdsr_addr_t a, input pdsr_word_t e);
    @(negedge clk_i);
    ps_rd_i = 1'b1;
    ps_addr_i = a;
    @(negedge clk_i);
    ps_rd_i = 1'b0;
    chk(ps_rdata_o, e);
  endtask
  task automatic ent(input int c);
    @(negedge clk_i);
    dbg_entry_i = 1'b1;
    dbg_mode_i = 1'b1;
    entry_cause_i = c[2:0];
    entry_thread_i = c[7:0];
    entry_hits_i = c[0] ? 4'hC : 4'h6;
    @(negedge clk_i);
    dbg_entry_i = 1'b0;
  endtask
  // ********************************
  // Scenarios
  // ********************************
  task automatic t_regs();
    rc(A_CAUSE, 32'h0);
    rc(8'h0B, 32'h0);
    wr(A_MEMSZ, 32'hFFFF_FFFF, 1'b1);
    rc(A_MEMSZ, MEM_BYTES_DEF & 32'hFFFF_FFFC);
    wr(A_SAVPC, 32'h1234_5678, 1'b0);
    rc(A_SAVPC, 32'h0);
    wr(A_SAVPC, 32'h1234_5678, 1'b1);
    rc(A_SAVPC, 32'h1234_5678);
    issue_mode_i = 1'b1;
    wr(A_STAT, 32'hFFFF_FFFF, 1'b1);
    rc(A_STAT, 32'h7DF);
    issue_mode_i = 1'b0;
    rc(A_STAT, 32'h6DF);
    wr(A_TSEL, 32'hFFFF_FF3C, 1'b1);
    rc(A_TSEL, 32'h3C);
    chk({24'h0, fetch_thread_o}, 32'h3C);
    wr(A_RSEL, 32'hFFFF_FFFF, 1'b1);
    rc(A_RSEL, 32'h1F);
    chk({27'h0, fetch_reg_o}, 32'h1F);
  endtask
  task automatic t_entry();
    for (int c = 1; c <= 5; c++) begin
      // Entry must win over a saved program counter write in the same cycle
      fork
        ent(c);
        wr(A_SAVPC, ~entry_pc_i, 1'b1);
      join
      rc(A_CAUSE, {14'h0, (c < 3) ? 2'h0 : (c[0] ? 2'h2 : 2'h1), (c == 1) ? 8'h0 : c[7:0], 5'h0, c[2:0]});
      pay = (c == 4) ? entry_addr_i : (c == 5) ? entry_res_id_i : pay;
      rc(A_PAYLD, pay);
    end
    rc(A_STAT, 32'h6DF);
    rc(A_SAVPC, entry_pc_i);
    rc(A_SAVSP, entry_sp_i);
  endtask
  task automatic t_stop();
    wr(A_STOP, 32'hFFFF_FFA5, 1'b1);
    @(negedge clk_i);
    chk({24'h0, thread_stop_o}, 32'h0);
    dbg_mode_i = 1'b0;
    repeat (2) @(negedge clk_i);
    chk({24'h0, thread_stop_o}, 32'hA5);
    rc(A_STOP, 32'hA5);
  endtask
  task automatic t_scr();
    u_dbg.put(3'h3, 32'hCAFE_0003);
    rc(A_SCR0 + 8'h03, 32'hCAFE_0003);
    wr(A_SCR0 + 8'h07, 32'h5A5A_0007, 1'b1);
    u_dbg.get(3'h7, d);
    chk(d, 32'h5A5A_0007);
    // Same word written from both sides at once: status port wins
    fork
      u_dbg.put(3'h1, 32'h0BAD_0001);
      wr(A_SCR0 + 8'h01, 32'h600D_0001, 1'b1);
    join
    rc(A_SCR0 + 8'h01, 32'h600D_0001);
    u_dbg.get(3'h1, d);
    chk(d, 32'h600D_0001);
  endtask
  task automatic t_osc();
    for (int k = 0; k < 4; k++) begin
      for (int n = 0; n <= k; n++) begin
        @(negedge clk_i) osc_i[k] = 1'b1;
        repeat (4) @(negedge clk_i);
        osc_i[k] = 1'b0;
        repeat (4) @(negedge clk_i);
      end
    end
    repeat (10) @(negedge clk_i);
    rst_i = 1'b1;
    repeat (2) @(negedge clk_i);
    rst_i = 1'b0;
    for (int k = 0; k < 4; k++) begin
      rc(A_OSC0 + 8'(k), 32'(k + 1));
    end
    rc(A_CAUSE, 32'h0);
  endtask
  task automatic end_sim();
    if (n_mismatch == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (6) @(negedge clk_i);
    rst_i = 1'b0;
    por_i = 1'b0;
    t_regs();
    t_entry();
    t_stop();
    t_scr();
    t_osc();
    end_sim();
  end
  initial begin
    #20000;
    n_mismatch++;
    end_sim();
  end
endmodule // testbench
`default_nettype wire
